// ==== design/bsad_boot_decode.sv ====
module bsad_boot_decode (
  input wire logic variant_8k_i, // High selects the 8K-word part
  input wire logic [1:0] boot_size_i, // Boot-size selection bits
  output logic [12:0] boot_start_o, // First word of boot section
  output logic [12:0] stall_start_o // First word of read-stall region
);

  // Both sections run to the top word, so only the start is kept
  assign boot_start_o = variant_8k_i ? bsad_pkg::BOOT_START_8K[boot_size_i] // R2
                                     : bsad_pkg::BOOT_START_4K[boot_size_i]; // R1

  // Fixed split, independent of the boot size
  assign stall_start_o = variant_8k_i ? bsad_pkg::STALL_START_8K // R4
                                      : bsad_pkg::STALL_START_4K; // R3

endmodule : bsad_boot_decode

// ==== design/bsad_boot_section_decode.sv ====
// Behaviour
// R1: 4K part boot starts per size bits
// R2: 8K part boot starts per size bits
// R3: 4K split at 0xC00, size independent
// R4: 8K split at 0x1C00, size independent
// R5: 4K word address is 12 bits
// R6: 4K page 32 words, word Z5:Z1, page Z12:Z6
// R7: 4K ignores pointer bits Z15:Z13
// R8: 8K word address is 13 bits
// R9: 8K page 64 words, word Z6:Z1, page Z13:Z7
// R10: 8K ignores pointer bits Z15:Z14
// R11: counter bit k comes from pointer bit k+1
// R12: Z0 selects load byte, zero for stores
// R13: page field selects erase and write page
// R14: word field selects buffer slot, zero on write
// R15: busy flag set for concurrent-region programming
// R16: halt CPU while programming read-stall region
// R17: boot size straps held from reset onward
module bsad_boot_section_decode (
  input wire logic clk_i, // 20 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic variant_8k_i, // Strap: 8K-word part when high
  input wire logic boot_size_sel_hi_i, // Strap: boot size upper bit
  input wire logic boot_size_sel_lo_i, // Strap: boot size lower bit
  input wire logic load_req_i, // CPU program-memory load request
  input wire logic [15:0] load_ptr_i, // Load byte pointer
  output logic [12:0] load_word_o, // Load word address
  output logic load_byte_hi_o, // Load takes high byte
  output logic load_block_o, // Load target is blocked
  output logic [6:0] flash_page_o, // Page for erase and write
  output logic [5:0] flash_word_o, // Buffer slot for fill
  output logic erase_o, // Page erase start pulse
  output logic write_o, // Page write start pulse
  output logic fill_o, // Buffer fill pulse
  output logic busy_o, // Programming in progress
  output logic region_busy_flag_o, // Concurrent region unreadable
  output logic cpu_halt_o, // CPU halted
  output logic [12:0] boot_start_o // Decoded boot section start
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    bsad_pkg::bsad_op_t op;
    logic busy;
    logic [15:0] cnt;
    logic [15:0] ptr;
    logic loaded;
    logic variant;
    logic [1:0] boot_size;
    logic [12:0] boot_start;
    logic region_busy;
    logic halt;
    logic ack;
    logic [31:0] dat;
    logic [6:0] page;
    logic [5:0] word;
    logic erase;
    logic write;
    logic fill;
    logic [12:0] ld_word;
    logic ld_hi;
    logic ld_block;
  } bsad_state_t;

  bsad_state_t state_reg;
  bsad_state_t state_next;

  logic [12:0] dec_boot_start;
  logic [12:0] dec_stall_start;
  logic [12:0] cmd_pc;
  logic [6:0] cmd_page;
  logic [5:0] cmd_word;
  logic [12:0] ld_pc;
  logic ld_hi;
  logic cmd_stall;
  logic bus_wr;
  logic cmd_accept;
  logic op_start;
  logic fill_go;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  // Decoded from held straps, so boundaries cannot move after reset
  bsad_boot_decode u_boot_decode (
    .variant_8k_i(state_reg.variant),
    .boot_size_i(state_reg.boot_size),
    .boot_start_o(dec_boot_start),
    .stall_start_o(dec_stall_start)
  );

  bsad_pointer_map u_cmd_map (
    .variant_8k_i(state_reg.variant),
    .ptr_i(state_reg.ptr),
    .pc_o(cmd_pc),
    .page_o(cmd_page),
    .word_o(cmd_word),
    .byte_hi_o()
  );

  bsad_pointer_map u_load_map (
    .variant_8k_i(state_reg.variant),
    .ptr_i(load_ptr_i),
    .pc_o(ld_pc),
    .page_o(),
    .word_o(),
    .byte_hi_o(ld_hi)
  );

  // Page-aligned boundary, so the word bits never change the answer
  assign cmd_stall = cmd_pc >= dec_stall_start; // R3 R4
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack;
  assign cmd_accept = bus_wr && (wb_adr_i == bsad_pkg::ADDR_COMMAND) && wb_sel_i[0] &&
                      (state_reg.op == bsad_pkg::OP_IDLE) && state_reg.loaded;
  assign op_start = cmd_accept && (wb_dat_i[bsad_pkg::CMD_ERASE_BIT] || wb_dat_i[bsad_pkg::CMD_WRITE_BIT]);
  assign fill_go = cmd_accept && !op_start && wb_dat_i[bsad_pkg::CMD_FILL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    state_next.ack = wb_cyc_i && wb_stb_i && !state_reg.ack;
    state_next.erase = 1'b0;
    state_next.write = 1'b0;
    state_next.fill = 1'b0;

    // Straps caught once, in the first cycle after reset release
    if (!state_reg.loaded) begin
      state_next.loaded = 1'b1; // R17
      state_next.variant = variant_8k_i; // R17
      state_next.boot_size = {boot_size_sel_hi_i, boot_size_sel_lo_i}; // R17
    end
    state_next.boot_start = dec_boot_start; // R1 R2

    // Read data captured as ack rises; unmapped reads return zero
    if (state_next.ack && !wb_we_i) begin
      case (wb_adr_i)
        bsad_pkg::ADDR_POINTER: state_next.dat = {16'h0000, state_reg.ptr};
        bsad_pkg::ADDR_STATUS: state_next.dat = {25'h0000000, state_reg.loaded, state_reg.boot_size,
                                                 state_reg.variant, state_reg.halt, state_reg.region_busy,
                                                 state_reg.op != bsad_pkg::OP_IDLE};
        bsad_pkg::ADDR_BOOT: state_next.dat = {19'h00000, state_reg.boot_start};
        bsad_pkg::ADDR_DECODE: state_next.dat = {18'h00000, cmd_word, 1'b0, cmd_page};
        default: state_next.dat = 32'h00000000;
      endcase
    end

    // Programming timer
    if (state_reg.op != bsad_pkg::OP_IDLE) begin
      if (state_reg.cnt == 16'h0001) begin
        state_next.op = bsad_pkg::OP_IDLE;
        state_next.busy = 1'b0;
        state_next.halt = 1'b0;
        state_next.cnt = 16'h0000;
      end else begin
        state_next.cnt = state_reg.cnt - 16'h0001;
      end
    end

    if (bus_wr && (wb_adr_i == bsad_pkg::ADDR_POINTER)) begin
      if (wb_sel_i[0]) begin
        state_next.ptr[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        state_next.ptr[15:8] = wb_dat_i[15:8];
      end
    end

    // Commands while programming are dropped; erase wins over write
    if (cmd_accept) begin
      if (op_start) begin
        state_next.op = wb_dat_i[bsad_pkg::CMD_ERASE_BIT] ? bsad_pkg::OP_ERASE : bsad_pkg::OP_WRITE;
        state_next.erase = wb_dat_i[bsad_pkg::CMD_ERASE_BIT];
        state_next.write = !wb_dat_i[bsad_pkg::CMD_ERASE_BIT];
        state_next.cnt = bsad_pkg::OP_CYCLES;
        state_next.busy = 1'b1;
        // Word field is not looked at for page write
        state_next.page = cmd_page; // R13 R14
        if (cmd_stall) begin
          state_next.halt = 1'b1; // R16
        end else begin
          state_next.region_busy = 1'b1; // R15
        end
      end else if (wb_dat_i[bsad_pkg::CMD_FILL_BIT]) begin
        // Buffer load also makes the concurrent region readable again
        state_next.fill = 1'b1;
        state_next.word = cmd_word; // R14
        state_next.region_busy = 1'b0;
      end else if (wb_dat_i[bsad_pkg::CMD_REEN_BIT]) begin
        state_next.region_busy = 1'b0;
      end
    end

    // Loads into a busy concurrent region are refused
    if (load_req_i) begin
      state_next.ld_word = ld_pc;
      state_next.ld_hi = ld_hi; // R12
      state_next.ld_block = (ld_pc < dec_stall_start) && state_reg.region_busy; // R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;
  assign load_word_o = state_reg.ld_word;
  assign load_byte_hi_o = state_reg.ld_hi;
  assign load_block_o = state_reg.ld_block;
  assign flash_page_o = state_reg.page;
  assign flash_word_o = state_reg.word;
  assign erase_o = state_reg.erase;
  assign write_o = state_reg.write;
  assign fill_o = state_reg.fill;
  assign busy_o = state_reg.busy;
  assign region_busy_flag_o = state_reg.region_busy;
  assign cpu_halt_o = state_reg.halt;
  assign boot_start_o = state_reg.boot_start;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_latency_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  boot_4k_a: assert property ((state_reg.loaded && !state_reg.variant && state_reg.boot_size == 2'h3) // R1
                              |=> boot_start_o == 13'h0F80)
    else $error("4K boot start wrong");

  boot_8k_a: assert property ((state_reg.loaded && state_reg.variant && state_reg.boot_size == 2'h0) // R2
                              |=> boot_start_o == 13'h1C00)
    else $error("8K boot start wrong");

  split_4k_a: assert property ((state_reg.loaded && !state_reg.variant) // R3
                               |-> (cmd_page < bsad_pkg::CONC_PAGES_4K) == (cmd_pc <= bsad_pkg::CONC_END_4K))
    else $error("4K region split wrong");

  split_8k_a: assert property ((state_reg.loaded && state_reg.variant) // R4
                               |-> (cmd_page < bsad_pkg::CONC_PAGES_8K) == (cmd_pc <= bsad_pkg::CONC_END_8K))
    else $error("8K region split wrong");

  pc_width_a: assert property ((load_req_i && !state_reg.variant) |=> !load_word_o[12]) // R5
    else $error("4K word address exceeds 12 bits");

  page_4k_a: assert property ((op_start && !state_reg.variant) |=> flash_page_o == $past(state_reg.ptr[12:6])) // R6
    else $error("4K page field wrong");

  page_8k_a: assert property ((op_start && state_reg.variant) |=> flash_page_o == $past(state_reg.ptr[13:7])) // R9
    else $error("8K page field wrong");

  load_map_a: assert property ((load_req_i && state_reg.variant) // R8 R12
                               |=> load_word_o == $past(load_ptr_i[13:1]) && load_byte_hi_o == $past(load_ptr_i[0]))
    else $error("load address mapping wrong");

  busy_set_a: assert property ((op_start && !cmd_stall) |=> region_busy_flag_o && busy_o && !cpu_halt_o) // R15
    else $error("region busy flag not set");

  halt_hold_a: assert property ((op_start && cmd_stall) |=> cpu_halt_o [*8]) // R16
    else $error("CPU not halted during stall-region program");

  halt_end_a: assert property ($fell(busy_o) |-> !cpu_halt_o) // R16
    else $error("halt outlives programming");

  straps_held_a: assert property ((state_reg.loaded && $past(state_reg.loaded)) // R17
                                  |-> $stable(state_reg.boot_size) && $stable(state_reg.variant))
    else $error("boot size changed after reset");

  boot_4k_big_a: assert property ((state_reg.loaded && !state_reg.variant && state_reg.boot_size == 2'h0) // R1
                                  |=> boot_start_o == 13'h0C00)
    else $error("4K large boot start wrong");

  boot_8k_small_a: assert property ((state_reg.loaded && state_reg.variant && state_reg.boot_size == 2'h3) // R2
                                    |=> boot_start_o == 13'h1F80)
    else $error("8K small boot start wrong");

  halt_4k_a: assert property ((op_start && !state_reg.variant) // R3
                              |=> cpu_halt_o == ($past(state_reg.ptr[12:1]) >= 12'hC00))
    else $error("4K stall split wrong");

  halt_8k_a: assert property ((op_start && state_reg.variant) // R4
                              |=> cpu_halt_o == ($past(state_reg.ptr[13:1]) >= 13'h1C00))
    else $error("8K stall split wrong");

  word_4k_a: assert property ((fill_go && !state_reg.variant) // R6
                              |=> flash_word_o == {1'b0, $past(state_reg.ptr[5:1])})
    else $error("4K word field wrong");

  word_8k_a: assert property ((fill_go && state_reg.variant) // R9
                              |=> flash_word_o == $past(state_reg.ptr[6:1]))
    else $error("8K word field wrong");

  load_4k_a: assert property ((load_req_i && !state_reg.variant) // R7 R11
                              |=> load_word_o == {1'b0, $past(load_ptr_i[12:1])})
    else $error("4K load address mapping wrong");

  byte_sel_a: assert property (load_req_i // R12
                               |=> load_byte_hi_o == $past(load_ptr_i[0]))
    else $error("load byte select wrong");

  op_pulse_a: assert property (op_start // R13
                               |=> (erase_o != write_o) && flash_page_o == $past(cmd_page))
    else $error("erase or write start wrong");

  fill_free_a: assert property (fill_o |-> !region_busy_flag_o) // R15
    else $error("fill left region busy");

  block_load_a: assert property ((load_req_i && state_reg.region_busy && ld_pc < dec_stall_start) // R15
                                 |=> load_block_o)
    else $error("busy region load not blocked");

  cmd_drop_a: assert property ((bus_wr && (wb_adr_i == bsad_pkg::ADDR_COMMAND) && busy_o)
                               |=> !erase_o && !write_o && !fill_o)
    else $error("command taken while busy");

  erase_conc_c: cover property (op_start && !cmd_stall && wb_dat_i[bsad_pkg::CMD_ERASE_BIT]);
  write_stall_c: cover property (op_start && cmd_stall && !wb_dat_i[bsad_pkg::CMD_ERASE_BIT]);
  fill_clear_c: cover property (region_busy_flag_o ##1 fill_o && !region_busy_flag_o);
  load_block_c: cover property (load_block_o);
  cmd_drop_c: cover property (bus_wr && (wb_adr_i == bsad_pkg::ADDR_COMMAND) && busy_o);

endmodule : bsad_boot_section_decode

// ==== design/bsad_pkg.sv ====
package bsad_pkg;

  localparam int unsigned PTR_W = 16;
  localparam int unsigned PC_W = 13;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned WORD_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Section boundaries, indexed by {boot_size_sel_hi, boot_size_sel_lo}
  localparam logic [12:0] BOOT_START_4K [4] = '{13'h0C00, 13'h0E00, 13'h0F00, 13'h0F80};
  localparam logic [12:0] BOOT_START_8K [4] = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
  localparam logic [12:0] CONC_END_4K = 13'h0BFF;
  localparam logic [12:0] STALL_START_4K = 13'h0C00;
  localparam logic [12:0] CONC_END_8K = 13'h1BFF;
  localparam logic [12:0] STALL_START_8K = 13'h1C00;
  localparam logic [6:0] CONC_PAGES_4K = 7'h60;
  localparam logic [6:0] CONC_PAGES_8K = 7'h70;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_POINTER = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BOOT = 8'h0C;
  localparam logic [7:0] ADDR_DECODE = 8'h10;

  localparam int unsigned CMD_ERASE_BIT = 0;
  localparam int unsigned CMD_WRITE_BIT = 1;
  localparam int unsigned CMD_FILL_BIT = 2;
  localparam int unsigned CMD_REEN_BIT = 3;

  localparam logic [15:0] OP_CYCLES = 16'h0040;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_WRITE
  } bsad_op_t;

endpackage : bsad_pkg

// ==== design/bsad_pointer_map.sv ====
module bsad_pointer_map (
  input wire logic variant_8k_i, // High selects the 8K-word part
  input wire logic [15:0] ptr_i, // Byte pointer
  output logic [12:0] pc_o, // Flash word address
  output logic [6:0] page_o, // Page index field
  output logic [5:0] word_o, // Word index field
  output logic byte_hi_o // High byte select for loads
);

  // Bit 0 never addresses words, so counter bit k sits at pointer bit k+1
  always_comb begin
    if (variant_8k_i) begin
      pc_o = ptr_i[13:1]; // R8 R10 R11
      page_o = ptr_i[13:7]; // R9
      word_o = ptr_i[6:1]; // R9
    end else begin
      pc_o = {1'b0, ptr_i[12:1]}; // R5 R7 R11
      page_o = ptr_i[12:6]; // R6
      word_o = {1'b0, ptr_i[5:1]}; // R6
    end
  end

  assign byte_hi_o = ptr_i[0]; // R12

endmodule : bsad_pointer_map

// ==== dv/bsad_cpu_model.sv ====
module bsad_cpu_model (
  input wire logic clk_i, // Core clock
  input wire logic cpu_halt_i, // Core stalled while high
  output logic load_req_o, // Program-memory load strobe
  output logic [15:0] load_ptr_o // Load byte pointer, bit 0 picks the byte
);
  timeunit 1ns;
  timeprecision 1ns;

  int hang;

  initial begin
    load_req_o = 1'b0;
    load_ptr_o = 16'h0000;
  end

  // A halted core issues nothing, so wait it out first
  task automatic load(input logic [15:0] ptr);
    hang = 0;
    while (cpu_halt_i !== 1'b0 && hang < 500) begin
      @(posedge clk_i);
      hang++;
    end
    @(posedge clk_i);
    load_req_o <= 1'b1;
    load_ptr_o <= ptr;
    @(posedge clk_i);
    load_req_o <= 1'b0;
    // Pointer is not held after the take; show junk, not the old value
    load_ptr_o <= ~ptr;
  endtask : load
endmodule : bsad_cpu_model

// ==== dv/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, variant_8k_i;
  logic boot_size_sel_hi_i, boot_size_sel_lo_i, load_req_i, load_byte_hi_o, load_block_o;
  logic erase_o, write_o, fill_o, busy_o, region_busy_flag_o, cpu_halt_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] load_ptr_i;
  logic [12:0] load_word_o, boot_start_o;
  logic [6:0] flash_page_o;
  logic [5:0] flash_word_o;
  int n_errors, cmp_count, seed, v, b, p, pg, e0, w0, f0, k, bz0, h0;
  int erase_cnt, write_cnt, fill_cnt, busy_cnt, halt_cnt;

  bsad_boot_section_decode u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .variant_8k_i(variant_8k_i), .boot_size_sel_hi_i(boot_size_sel_hi_i),
    .boot_size_sel_lo_i(boot_size_sel_lo_i), .load_req_i(load_req_i), .load_ptr_i(load_ptr_i),
    .load_word_o(load_word_o), .load_byte_hi_o(load_byte_hi_o), .load_block_o(load_block_o),
    .flash_page_o(flash_page_o), .flash_word_o(flash_word_o), .erase_o(erase_o), .write_o(write_o),
    .fill_o(fill_o), .busy_o(busy_o), .region_busy_flag_o(region_busy_flag_o), .cpu_halt_o(cpu_halt_o),
    .boot_start_o(boot_start_o));

  bsad_cpu_model u_cpu (.clk_i(clk_i), .cpu_halt_i(cpu_halt_o), .load_req_o(load_req_i),
    .load_ptr_o(load_ptr_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Pulses are only one cycle wide, so tally them rather than catch them
  always @(posedge clk_i) begin
    erase_cnt <= erase_cnt + erase_o;
    write_cnt <= write_cnt + write_o;
    fill_cnt <= fill_cnt + fill_o;
    busy_cnt <= busy_cnt + busy_o;
    halt_cnt <= halt_cnt + cpu_halt_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
    if (i == 20) begin
      n_errors++;
      summarize();
    end
  endtask : wb

  task automatic wait_idle();
    int i;
    for (i = 0; i < 300 && busy_o !== 1'b0; i++) @(posedge clk_i);
    #1;
    if (i == 300) begin
      n_errors++;
      summarize();
    end
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 39180;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    variant_8k_i = 1'b0;
    boot_size_sel_hi_i = 1'b0;
    boot_size_sel_lo_i = 1'b0;
    for (int c = 0; c < 8; c++) begin
      v = c / 4;
      b = c % 4;
      @(posedge clk_i);
      rst_i <= 1'b1;
      variant_8k_i <= v[0];
      boot_size_sel_hi_i <= b[1];
      boot_size_sel_lo_i <= b[0];
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      k = (v ? 'h2000 : 'h1000) - (128 << (3 - b));
      chk("boot_start", boot_start_o, k);
      wb(0, bsad_pkg::ADDR_BOOT, 0);
      // Straps move after capture; decode must not follow them
      variant_8k_i <= ~v[0];
      boot_size_sel_hi_i <= ~b[1];
      chk("boot_reg", q, k);
      wb(0, bsad_pkg::ADDR_STATUS, 0);
      chk("status", q, v * 8 + b * 16 + 64);
      repeat (3) begin
        p = $random(seed);
        u_cpu.load(p[15:0]);
        #1;
        chk("load_word", load_word_o, (p >> 1) & (v ? 'h1FFF : 'hFFF));
        chk("load_byte", load_byte_hi_o, p & 1);
        chk("load_block", load_block_o, 0);
      end
      p = $random(seed);
      wb(1, bsad_pkg::ADDR_POINTER, p);
      wb(0, bsad_pkg::ADDR_DECODE, 0);
      chk("decode", q, ((p >> (6 + v)) & 'h7F) | (((p >> 1) & (v ? 'h3F : 'h1F)) << 8));
      // Last concurrent page, then first stall page, with junk in ignored bits
      for (int s = 0; s < 2; s++) begin
        pg = (v ? 'h6F : 'h5F) + s;
        p = (pg << (6 + v)) | (v ? 'hC000 : 'hE000);
        e0 = erase_cnt;
        w0 = write_cnt;
        bz0 = busy_cnt;
        h0 = halt_cnt;
        wb(1, bsad_pkg::ADDR_POINTER, p);
        // Both start bits on the first pass: erase must win
        wb(1, bsad_pkg::ADDR_COMMAND, s ? 2 : 3);
        repeat (2) @(posedge clk_i);
        #1;
        chk("page", flash_page_o, pg);
        chk("ops", (erase_cnt - e0) * 2 + write_cnt - w0, s ? 1 : 2);
        chk("region_busy", region_busy_flag_o, s == 0);
        chk("halt", cpu_halt_o, s);
        if (s == 0) begin
          u_cpu.load(p[15:0]);
          #1;
          chk("blocked", load_block_o, 1);
          // Commands during programming are dropped
          wb(1, bsad_pkg::ADDR_COMMAND, 2);
        end
        wait_idle();
        chk("halt_end", cpu_halt_o, 0);
        chk("busy_len", busy_cnt - bz0, bsad_pkg::OP_CYCLES);
        chk("halt_len", halt_cnt - h0, s ? bsad_pkg::OP_CYCLES : 16'h0000);
        chk("ops_after", (erase_cnt - e0) * 2 + write_cnt - w0, s ? 1 : 2);
        if (s == 0) begin
          f0 = fill_cnt;
          p = $random(seed) & 'hFFFE;
          wb(1, bsad_pkg::ADDR_POINTER, p);
          wb(1, bsad_pkg::ADDR_COMMAND, c[0] ? 4 : 8);
          repeat (2) @(posedge clk_i);
          #1;
          chk("region_free", region_busy_flag_o, 0);
          chk("fills", fill_cnt - f0, c[0]);
          if (c[0]) chk("slot", flash_word_o, (p >> 1) & (v ? 'h3F : 'h1F));
        end
      end
      chk("boot_hold", boot_start_o, k);
      $display("test config %0d done", c);
    end
    wb(0, 8'h20, 0);
    chk("unmapped", q, 0);
    wb(0, bsad_pkg::ADDR_COMMAND, 0);
    chk("cmd_read", q, 0);
    $display("test bus done");
    summarize();
  end
endmodule : tb
